//--- logic/fcu_error_out_pins.sv
// Error-out pin pair shaper: dual-rail toggling or static idle levels
`timescale 1ns/10ps
module fcu_error_out_pins (
   input wire logic aclk,
   input wire logic aresetn,
   fcu_error_out_pins_if.drv  io
);
   logic e0_d;
   logic e1_d;

   // Fault shows as both pins low; dual rail toggles on safe ticks
   always_comb
   begin
      e0_d = io.e0;
      e1_d = io.e1;
      if (io.on)
      begin
         e0_d = 1'b0;
         e1_d = 1'b0;
      end
      else if (io.stat)
      begin
         e0_d = 1'b1;
         e1_d = 1'b0;
      end
      else if (io.tick || (io.e0 == io.e1))
      begin
         e0_d = ~io.e0;
         e1_d = io.e0;
      end
   end

   // Reset leaves the pins in dual-rail idle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         io.e0 <= 1'b0;
         io.e1 <= 1'b1;
      end
      else
      begin
         io.e0 <= e0_d;
         io.e1 <= e1_d;
      end
   end

   sequence s_idle2;
      !io.on && !io.stat ##1 !io.on && !io.stat;
   endsequence

   a_dual_rail_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      s_idle2 |-> (io.e0 != io.e1))
      else $error("error-out pins equal while idle");
endmodule

//--- logic/fcu_error_out_pins_if.sv
// Link between the fault core and the error-out pin shaper
`timescale 1ns/10ps
interface fcu_error_out_pins_if;
   logic tick;
   logic on;
   logic stat;
   logic e0;
   logic e1;
   modport ctl (output tick, output on, output stat, input e0, input e1);
   modport drv (input tick, input on, input stat, output e0, output e1);
endinterface

//--- logic/fcu_pkg.sv
// Types shared by the fault unit modules
package fcu_pkg;

   typedef enum logic [3:0]
   {
      ST_CFG = 4'h1,
      ST_NRM = 4'h2,
      ST_ALM = 4'h4,
      ST_FLT = 4'h8
   } fcu_state_t;

endpackage

//--- logic/fcu_regs.svh
// Register offsets, field positions, reset values and timing for the fault unit
`ifndef FCU_REGS_SVH
`define FCU_REGS_SVH

`define FCU_A_CTRL    8'h00
`define FCU_A_STATE   8'h04
`define FCU_A_FLT     8'h08
`define FCU_A_RF      8'h0c
`define FCU_A_EOEN    8'h10
`define FCU_A_RSTEN   8'h14
`define FCU_A_ALMEN   8'h18
`define FCU_A_DELTA   8'h1c
`define FCU_A_PROTO   8'h20
`define FCU_A_INJ     8'h24
`define FCU_A_ISTAT   8'h28
`define FCU_A_IMASK   8'h2c
`define FCU_A_ID      8'h30

`define FCU_CH_LVD    1
`define FCU_CH_HVD    2
`define FCU_CH_SELF   8

`define FCU_EV_FAULT  0
`define FCU_EV_ALARM  1
`define FCU_EV_OSL    2
`define FCU_EV_REFUSE 3

`define FCU_RST_DELTA 16'h0000
`define FCU_RST_PROTO 1'b0

`define FCU_RESP_OK   2'b00
`define FCU_RESP_ERR  2'b10

`define FCU_CLK_NS    20
`define FCU_ERROR_OUT_PINS_NS   250000
`define FCU_ERROR_OUT_PINS_CYC  (`FCU_ERROR_OUT_PINS_NS / `FCU_CLK_NS)
`define FCU_ALARM_CYC 1000
`define FCU_SAFE_DIV  3

`endif

//--- logic/fcu_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module fcu_sync #(
   parameter int W = 1
)(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] o_d;

   // Output moves only once stages two and three agree
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      assign o_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : dout[i];
   end

   // First stage feeds only the second, no logic taps it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         dout <= '0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         dout <= o_d;
      end
   end
endmodule

//--- logic/fcu_top.sv
// Fault collection unit: AXI4-Lite registers, fault flags, state machine, error-out
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "fcu_regs.svh"

module fcu_top #(
   parameter int          NF           = 16,
   parameter int          VD           = 4,
   parameter int          ERROR_OUT_PINS_MIN_CYC = `FCU_ERROR_OUT_PINS_CYC,
   parameter int          ALARM_CYC    = `FCU_ALARM_CYC,
   parameter int          SAFE_DIV     = `FCU_SAFE_DIV,
   parameter logic [31:0] ID_CODE      = 32'h0000_5a5a // Arbitrary value
)(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   output logic [1:0]         s_axi_bresp,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   input  wire logic [7:0]    s_axi_araddr,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   input  wire logic [NF-1:0] fault_src,
   input  wire logic [VD-1:0] low_voltage_detect,
   input  wire logic [VD-1:0] high_voltage_detect,
   output logic               error_out0,
   output logic               error_out1,
   output logic               reset_req,
   output logic               irq
);
   localparam int          SELF = `FCU_CH_SELF;
   localparam logic [32:0] ONE  = 33'h1;
   localparam logic [31:0] NFM  = 32'((ONE << NF) - ONE);

   // Refuse sizes the channel map or divider cannot serve
   if (NF < 9 || NF > 32 || VD < 1 || SAFE_DIV < 2 || SAFE_DIV > 255)
   begin : g_bad
      $error("fcu_top: unsupported parameter set");
   end

   function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (n & m);
   endfunction

   fcu_pkg::fcu_state_t st_q, st_d;
   logic [31:0]       cnt_q, cnt_d, load;
   logic [7:0]        div_q, div_d;
   logic              tick;
   logic [NF+2*VD-1:0] sync_s;
   logic [NF-1:0]     src, cur, seen_q, seen_d, flt_q, flt_d, flt_clr;
   logic [31:0]       rf_q, rf_d, eoen_q, eoen_d, rsten_q, rsten_d;
   logic [31:0]       almen_q, almen_d, inj_q, inj_d;
   logic [15:0]       delta_q, delta_d;
   logic              proto_q, proto_d;
   logic [3:0]        ist_q, ist_d, imask_q, imask_d, ev;
   logic              osl_ev, rst_d, irq_d, go_nrm, go_cfg, bad, refuse;
   logic              aw_full_q, aw_full_d, w_full_q, w_full_d, do_wr;
   logic [7:0]        waddr_q, waddr_d, raddr;
   logic [31:0]       wdat_q, wdat_d, rdat_d, rd;
   logic [3:0]        wstb_q, wstb_d;
   logic              awr_d, wr_d, bv_d, arr_d, rv_d, rerr;
   logic [1:0]        br_d, rr_d;

   fcu_error_out_pins_if eio ();

   fcu_sync #(.W(NF + 2 * VD)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     ({high_voltage_detect, low_voltage_detect, fault_src}),
      .dout    (sync_s)
   );

   fcu_error_out_pins u_error_out_pins (
      .aclk    (aclk),
      .aresetn (aresetn),
      .io      (eio)
   );

   // Safe clock stands in for the internal RC oscillator as a tick
   assign tick     = (div_q == 8'(SAFE_DIV - 1));
   assign div_d    = tick ? 8'h00 : div_q + 8'h01;
   assign eio.tick = tick;
   assign eio.on   = (st_q == fcu_pkg::ST_FLT);
   assign eio.stat = proto_q;
   assign error_out0 = eio.e0;
   assign error_out1 = eio.e1;

   // Source merge: detectors are ORed, injected faults join their input
   always_comb
   begin
      src = sync_s[NF-1:0] | inj_q[NF-1:0];
      src[`FCU_CH_LVD] = src[`FCU_CH_LVD] | (|sync_s[NF+VD-1:NF]);
      src[`FCU_CH_HVD] = src[`FCU_CH_HVD] | (|sync_s[NF+2*VD-1:NF+VD]);
   end

   // AXI handshake: address and data in either order, answer after both
   always_comb
   begin
      aw_full_d = aw_full_q;
      w_full_d  = w_full_q;
      waddr_d   = waddr_q;
      wdat_d    = wdat_q;
      wstb_d    = wstb_q;
      do_wr     = aw_full_q && w_full_q && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_full_d = 1'b1;
         waddr_d   = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_full_d = 1'b1;
         wdat_d   = s_axi_wdata;
         wstb_d   = s_axi_wstrb;
      end
      if (do_wr)
      begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
      end
      awr_d = !aw_full_d;
      wr_d  = !w_full_d;
   end

   // Register writes; configuration only lands in config state
   always_comb
   begin
      rf_d    = rf_q;
      eoen_d  = eoen_q;
      rsten_d = rsten_q;
      almen_d = almen_q;
      delta_d = delta_q;
      proto_d = proto_q;
      imask_d = imask_q;
      inj_d   = inj_q;
      inj_d[SELF] = 1'b0;
      flt_clr = '0;
      go_nrm  = 1'b0;
      go_cfg  = 1'b0;
      bad     = 1'b0;
      refuse  = 1'b0;
      if (do_wr)
      begin
         case (waddr_q)
            `FCU_A_CTRL:
            begin
               go_nrm = wstb_q[0] && wdat_q[0];
               go_cfg = wstb_q[0] && !wdat_q[0];
            end
            `FCU_A_FLT:   flt_clr = NF'(mrg(32'h0, wdat_q, wstb_q));
            `FCU_A_IMASK: imask_d = 4'(mrg({28'h0, imask_q}, wdat_q, wstb_q));
            `FCU_A_INJ:   inj_d   = mrg(inj_q & ~(32'h1 << SELF), wdat_q, wstb_q) & NFM;
            `FCU_A_ISTAT, `FCU_A_STATE, `FCU_A_ID: bad = 1'b0;
            `FCU_A_RF, `FCU_A_EOEN, `FCU_A_RSTEN, `FCU_A_ALMEN, `FCU_A_DELTA, `FCU_A_PROTO:
            begin
               if (st_q != fcu_pkg::ST_CFG)
                  refuse = 1'b1;
               else
               begin
                  case (waddr_q)
                     `FCU_A_RF:    rf_d    = mrg(rf_q, wdat_q, wstb_q) & NFM;
                     `FCU_A_EOEN:  eoen_d  = mrg(eoen_q, wdat_q, wstb_q) & NFM;
                     `FCU_A_RSTEN: rsten_d = mrg(rsten_q, wdat_q, wstb_q) & NFM;
                     `FCU_A_ALMEN: almen_d = mrg(almen_q, wdat_q, wstb_q) & NFM;
                     `FCU_A_DELTA: delta_d = 16'(mrg({16'h0, delta_q}, wdat_q, wstb_q));
                     default:      proto_d = 1'(mrg({31'h0, proto_q}, wdat_q, wstb_q));
                  endcase
               end
            end
            default: bad = 1'b1;
         endcase
      end
      br_d = s_axi_bresp;
      if (do_wr)
         br_d = (bad || refuse) ? `FCU_RESP_ERR : `FCU_RESP_OK;
      bv_d = do_wr || (s_axi_bvalid && !s_axi_bready);
   end

   // Fault flags: hardware recoverable follow the source at each safe tick,
   // software recoverable hold until cleared; a set on the tick beats a clear
   always_comb
   begin
      cur    = seen_q | src;
      seen_d = tick ? '0 : cur;
      flt_d  = flt_q & ~(flt_clr & rf_q[NF-1:0]);
      osl_ev = 1'b0;
      if (tick)
      begin
         flt_d = (~rf_q[NF-1:0] & src) | (rf_q[NF-1:0] & (flt_d | cur));
         // Pulse shorter than a safe period on a lone error-out reaction
         osl_ev = |(cur & ~src & ~rf_q[NF-1:0] & eoen_q[NF-1:0]
                    & ~rsten_q[NF-1:0] & ~almen_q[NF-1:0]);
      end
   end

   // Main state machine; alarm timer and error-out timer share one counter
   assign load = 32'(ERROR_OUT_PINS_MIN_CYC) + 32'(delta_q) * 32'(SAFE_DIV);
   always_comb
   begin
      logic unsafe;
      logic any;
      logic enter;
      unsafe = |(flt_q & ~almen_q[NF-1:0]);
      any    = |flt_q;
      enter  = 1'b0;
      st_d   = st_q;
      cnt_d  = (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
      ev     = 4'h0;
      ev[`FCU_EV_OSL]    = osl_ev;
      ev[`FCU_EV_REFUSE] = refuse;
      rst_d  = osl_ev;
      case (st_q)
         fcu_pkg::ST_CFG:
            if (go_nrm)
               st_d = fcu_pkg::ST_NRM;
         fcu_pkg::ST_NRM:
            if (unsafe)
               enter = 1'b1;
            else if (any)
            begin
               st_d  = fcu_pkg::ST_ALM;
               cnt_d = 32'(ALARM_CYC);
               ev[`FCU_EV_ALARM] = 1'b1;
            end
            else if (go_cfg)
               st_d = fcu_pkg::ST_CFG;
         fcu_pkg::ST_ALM:
            if (unsafe || cnt_q == 32'h0)
               enter = 1'b1;
            else if (!any)
               st_d = fcu_pkg::ST_NRM;
         fcu_pkg::ST_FLT:
            if (cnt_q == 32'h0 && !any)
               st_d = fcu_pkg::ST_NRM;
         default:
            st_d = fcu_pkg::ST_CFG;
      endcase
      // Fault entry drives error-out whatever its enable says
      if (enter)
      begin
         st_d  = fcu_pkg::ST_FLT;
         cnt_d = load;
         ev[`FCU_EV_FAULT] = 1'b1;
         rst_d = rst_d || |(flt_q & rsten_q[NF-1:0]);
      end
      ist_d = (ist_q & ~(waddr_q == `FCU_A_ISTAT && do_wr ? wdat_q[3:0] & {4{wstb_q[0]}} : 4'h0)) | ev;
      irq_d = |(ist_d & imask_d);
   end

   // Read path
   assign raddr = {s_axi_araddr[7:2], 2'b00};
   always_comb
   begin
      rd   = 32'h0;
      rerr = 1'b0;
      case (raddr)
         `FCU_A_CTRL:  rd = {31'h0, st_q != fcu_pkg::ST_CFG};
         `FCU_A_STATE: rd = {28'h0, st_q};
         `FCU_A_FLT:   rd = NFM & 32'(flt_q);
         `FCU_A_RF:    rd = rf_q;
         `FCU_A_EOEN:  rd = eoen_q;
         `FCU_A_RSTEN: rd = rsten_q;
         `FCU_A_ALMEN: rd = almen_q;
         `FCU_A_DELTA: rd = {16'h0, delta_q};
         `FCU_A_PROTO: rd = {31'h0, proto_q};
         `FCU_A_INJ:   rd = inj_q;
         `FCU_A_ISTAT: rd = {28'h0, ist_q};
         `FCU_A_IMASK: rd = {28'h0, imask_q};
         `FCU_A_ID:    rd = ID_CODE;
         default:      rerr = 1'b1;
      endcase
      rdat_d = s_axi_rdata;
      rr_d   = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rdat_d = rd;
         rr_d   = rerr ? `FCU_RESP_ERR : `FCU_RESP_OK;
      end
      rv_d  = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
      arr_d = !rv_d;
   end

   // All state registers; outputs other than error_out0 and error_out1 come straight from here
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q          <= fcu_pkg::ST_CFG;
         cnt_q         <= 32'h0;
         div_q         <= 8'h00;
         seen_q        <= '0;
         flt_q         <= '0;
         rf_q          <= 32'h0;
         eoen_q        <= 32'h0;
         rsten_q       <= 32'h0;
         almen_q       <= 32'h0;
         inj_q         <= 32'h0;
         delta_q       <= `FCU_RST_DELTA;
         proto_q       <= `FCU_RST_PROTO;
         ist_q         <= 4'h0;
         imask_q       <= 4'h0;
         reset_req     <= 1'b0;
         irq           <= 1'b0;
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         waddr_q       <= 8'h00;
         wdat_q        <= 32'h0;
         wstb_q        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'b00;
      end
      else
      begin
         st_q          <= st_d;
         cnt_q         <= cnt_d;
         div_q         <= div_d;
         seen_q        <= seen_d;
         flt_q         <= flt_d;
         rf_q          <= rf_d;
         eoen_q        <= eoen_d;
         rsten_q       <= rsten_d;
         almen_q       <= almen_d;
         inj_q         <= inj_d;
         delta_q       <= delta_d;
         proto_q       <= proto_d;
         ist_q         <= ist_d;
         imask_q       <= imask_d;
         reset_req     <= rst_d;
         irq           <= irq_d;
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         waddr_q       <= waddr_d;
         wdat_q        <= wdat_d;
         wstb_q        <= wstb_d;
         s_axi_awready <= awr_d;
         s_axi_wready  <= wr_d;
         s_axi_bvalid  <= bv_d;
         s_axi_bresp   <= br_d;
         s_axi_arready <= arr_d;
         s_axi_rvalid  <= rv_d;
         s_axi_rdata   <= rdat_d;
         s_axi_rresp   <= rr_d;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_enter_fault;
      st_q != fcu_pkg::ST_FLT ##1 st_q == fcu_pkg::ST_FLT;
   endsequence

   sequence s_alarm_held;
      st_q == fcu_pkg::ST_ALM ##1 st_q == fcu_pkg::ST_ALM;
   endsequence

   a_error_out_pins_hold: assert property (
      (st_q == fcu_pkg::ST_FLT && cnt_q != 32'h0) |=> (st_q == fcu_pkg::ST_FLT && !error_out0 && !error_out1))
      else $error("error-out released before its duration");
   a_delta_load: assert property (
      s_enter_fault |-> cnt_q == 32'(ERROR_OUT_PINS_MIN_CYC) + 32'(delta_q) * 32'(SAFE_DIV))
      else $error("error-out duration not loaded from delta");
   a_alarm_quiet: assert property (
      s_alarm_held |-> error_out0 != error_out1)
      else $error("error-out moved during alarm");
   a_self_pulse: assert property (
      $rose(inj_q[SELF]) |=> !inj_q[SELF])
      else $error("self-test injection not a single pulse");
   a_inject_held: assert property (
      !(do_wr && waddr_q == `FCU_A_INJ) |=> ((inj_q ^ $past(inj_q)) & ~(32'h1 << SELF)) == 32'h0)
      else $error("injected fault dropped without clear");
   a_osl_reset: assert property (
      osl_ev |=> reset_req ##1 !reset_req || osl_ev)
      else $error("supervision reset not issued");
   a_safe_tick: assert property (
      tick |=> !tick ##1 (SAFE_DIV == 2 || !tick))
      else $error("safe tick spacing wrong");
   a_vd_merge: assert property (
      (|sync_s[NF+VD-1:NF]) |-> src[`FCU_CH_LVD] && ((|sync_s[NF+2*VD-1:NF+VD]) ? src[`FCU_CH_HVD] : 1'b1))
      else $error("voltage detect not merged");
   a_cfg_lock: assert property (
      (do_wr && st_q != fcu_pkg::ST_CFG && (waddr_q == `FCU_A_RF || waddr_q == `FCU_A_DELTA))
         |=> $stable(rf_q) && $stable(delta_q) && s_axi_bresp == `FCU_RESP_ERR)
      else $error("configuration changed outside config state");
endmodule

//--- tb/fault_collection_error_out_tb.sv
// Register-level tests of the fault unit with a pin supervisor attached
`timescale 1ns/10ps
`include "fcu_regs.svh"
module fault_collection_error_out_tb;
   localparam int         EMIN = 20;
   localparam int         SDIV = 3;
   localparam int         ALM  = 30;
   localparam logic [1:0] OK   = `FCU_RESP_OK;
   localparam logic [1:0] ER   = `FCU_RESP_ERR;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [15:0] fault_src = 16'h0;
   logic [3:0]  low_voltage_detect = 4'h0, high_voltage_detect = 4'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        error_out0, error_out1, reset_req, irq, eo_prev;
   int          error_cnt = 0, cmp_count = 0, rst_seen = 0, pulses, last_len, p0, p1;

   always #10 aclk = ~aclk;

   fcu_top #(.ERROR_OUT_PINS_MIN_CYC(EMIN), .ALARM_CYC(ALM), .SAFE_DIV(SDIV)) fcu_top_inst (.*);
   fcu_sup_model #(.MIN_LEN(EMIN)) fcu_sup_model_inst (.clk(aclk), .rst_n(aresetn), .eo0(error_out0),
      .eo1(error_out1), .pulses(pulses), .last_len(last_len));

   // Reset request pulses counted for later comparison
   always @(posedge aclk)
      if (reset_req === 1'b1) rst_seen <= rst_seen + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      chk({31'h0, s_axi_bvalid}, 32'h1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      chk({31'h0, s_axi_rvalid}, 32'h1);
      q = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      rd(a, q, r);
      chk(q, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // Polls the state register; a stuck fault shows as a mismatch
   task automatic wait_nrm();
      logic [31:0] q;
      logic [1:0]  r;
      int          n = 0;
      do
      begin
         rd(`FCU_A_STATE, q, r);
         n++;
      end
      while (q !== 32'h2 && n < 60);
      chk(q, 32'h2);
   endtask

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog well beyond the fewer than a thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      // Idle pins: opposite levels, one toggle per safe tick
      chk({31'h0, error_out0 ^ error_out1}, 32'h1);
      eo_prev = error_out0;
      repeat (SDIV) @(posedge aclk);
      chk({31'h0, error_out0}, {31'h0, ~eo_prev});
      rdc(`FCU_A_STATE, 32'h1, OK);
      rdc(`FCU_A_DELTA, 32'h0, OK);
      rdc(`FCU_A_PROTO, 32'h0, OK);
      rdc(8'h3c, 32'h0, ER);
      wr(8'h3c, 32'h1, ER);
      // Setup: channels 1 and 8 software recoverable
      wr(`FCU_A_RF, 32'h102, OK);
      wr(`FCU_A_RSTEN, 32'h2, OK);
      wr(`FCU_A_EOEN, 32'h40, OK);
      wr(`FCU_A_ALMEN, 32'h10, OK);
      wr(`FCU_A_DELTA, 32'h2, OK);
      wr(`FCU_A_IMASK, 32'hf, OK);
      rdc(`FCU_A_RF, 32'h102, OK);
      wr(`FCU_A_CTRL, 32'h1, OK);
      rdc(`FCU_A_STATE, 32'h2, OK);
      // Locked setup refused, flagged, masked, then cleared
      wr(`FCU_A_DELTA, 32'h7, ER);
      rdc(`FCU_A_DELTA, 32'h2, OK);
      rdc(`FCU_A_ISTAT, 32'h8, OK);
      chk({31'h0, irq}, 32'h1);
      wr(`FCU_A_IMASK, 32'h0, OK);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      wr(`FCU_A_IMASK, 32'hf, OK);
      wr(`FCU_A_ISTAT, 32'h8, OK);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      // Fault with error-out disabled still holds both pins low
      p0 = pulses;
      fault_src <= 16'h0008;
      repeat (10) @(posedge aclk);
      fault_src <= 16'h0000;
      wait_nrm();
      // Supervisor counts the pulse only once the pins are idle again
      repeat (3) @(posedge aclk);
      chk(pulses - p0, 1);
      chk({31'h0, last_len >= EMIN + 2 * SDIV && last_len <= EMIN + 2 * SDIV + 2}, 32'h1);
      rdc(`FCU_A_ISTAT, 32'h1, OK);
      wr(`FCU_A_ISTAT, 32'h1, OK);
      // Alarm cleared well before its timeout leaves the pins alone
      fault_src <= 16'h0010;
      repeat (10) @(posedge aclk);
      fault_src <= 16'h0000;
      repeat (ALM + 20) @(posedge aclk);
      chk(pulses - p0, 1);
      rdc(`FCU_A_STATE, 32'h2, OK);
      rdc(`FCU_A_ISTAT, 32'h2, OK);
      wr(`FCU_A_ISTAT, 32'h2, OK);
      // Pulse shorter than a safe period with only an error-out reaction;
      // aligned through a rail toggle so that no safe tick sees it high
      p1 = rst_seen;
      eo_prev = error_out0;
      do
      begin
         @(negedge aclk);
      end
      while (error_out0 === eo_prev);
      repeat (2) @(posedge aclk);
      fault_src <= 16'h0040;
      repeat (2) @(posedge aclk);
      fault_src <= 16'h0000;
      repeat (12) @(posedge aclk);
      chk(rst_seen - p1, 1);
      rdc(`FCU_A_ISTAT, 32'h4, OK);
      rdc(`FCU_A_STATE, 32'h2, OK);
      wr(`FCU_A_ISTAT, 32'h4, OK);
      // Any low-voltage source lands on channel 1 and requests a reset
      p1 = rst_seen;
      low_voltage_detect <= 4'h4;
      repeat (10) @(posedge aclk);
      low_voltage_detect <= 4'h0;
      repeat (EMIN + 2 * SDIV + 5) @(posedge aclk);
      rdc(`FCU_A_FLT, 32'h2, OK);
      chk(rst_seen - p1, 1);
      wr(`FCU_A_FLT, 32'h2, OK);
      wait_nrm();
      // Any high-voltage source lands on channel 2
      high_voltage_detect <= 4'h8;
      repeat (10) @(posedge aclk);
      rdc(`FCU_A_FLT, 32'h4, OK);
      high_voltage_detect <= 4'h0;
      wait_nrm();
      // Injected self-test faults: input 8 pulses once, input 5 holds
      wr(`FCU_A_INJ, 32'h120, OK);
      repeat (10) @(posedge aclk);
      rdc(`FCU_A_INJ, 32'h20, OK);
      rdc(`FCU_A_FLT, 32'h120, OK);
      wr(`FCU_A_INJ, 32'h0, OK);
      repeat (10) @(posedge aclk);
      rdc(`FCU_A_FLT, 32'h100, OK);
      wr(`FCU_A_FLT, 32'h100, OK);
      wait_nrm();
      // Back to config, static protocol: pins rest at fixed opposite levels
      wr(`FCU_A_CTRL, 32'h0, OK);
      rdc(`FCU_A_STATE, 32'h1, OK);
      wr(`FCU_A_PROTO, 32'h1, OK);
      repeat (SDIV + 1) @(posedge aclk);
      chk({30'h0, error_out0, error_out1}, 32'h2);
      repeat (SDIV) @(posedge aclk);
      chk({30'h0, error_out0, error_out1}, 32'h2);
      tally_and_finish();
   end
endmodule

//--- tb/fcu_sup_model.sv
// Supervisor model that times fault pulses on the two error-out pins
`timescale 1ns/10ps
module fcu_sup_model #(
   parameter int MIN_LEN = 20
)(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic eo0,
   input  wire logic eo1,
   output int        pulses,
   output int        last_len
);
   int run;

   // Both pins low is a fault; pulses under MIN_LEN are not counted as valid
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         run <= 0;
         pulses <= 0;
         last_len <= 0;
      end
      else if (eo0 === 1'b0 && eo1 === 1'b0)
         run <= run + 1;
      else if (run != 0)
      begin
         if (run >= MIN_LEN)
            pulses <= pulses + 1;
         last_len <= run;
         run <= 0;
      end
   end
endmodule
